/* hdl/dcc_pkg.sv */
/*
 * Package for the dual comparator control block: register offsets,
 * field positions, reset values and the structs that carry control
 * fields and analog selections.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package dcc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL1 = 8'h00;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_FLAG = 8'h0c;
    localparam logic [7:0] OFF_IEN = 8'h10;
    localparam logic [7:0] OFF_MCTL = 8'h14;
    localparam logic [7:0] OFF_PDIR = 8'h18;
    localparam logic [7:0] OFF_PDAT = 8'h1c;

    // Field positions
    localparam int FLAG_CM1_BIT = 5;
    localparam int FLAG_CM2_BIT = 6;
    localparam int MCTL_PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int MCTL_GIE_BIT = 7;
    localparam int PDIR_CM1_BIT = 2;
    localparam int PDIR_CM2_BIT = 1;

    // Encodings
    localparam logic [1:0] EVT_OFF = 2'h0;
    localparam logic [1:0] EVT_RISE = 2'h1;
    localparam logic [1:0] EVT_FALL = 2'h2;
    localparam logic [1:0] EVT_ANY = 2'h3;
    localparam logic [1:0] INM_PIN_B = 2'h0;
    localparam logic [1:0] INM_PIN_C = 2'h1;
    localparam logic [1:0] INM_PIN_D = 2'h2;
    localparam logic [1:0] INM_FIXED_REF = 2'h3;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h1f;
    localparam logic [1:0] PDIR_RST = 2'h3;
    localparam logic [1:0] PDAT_RST = 2'h0;

    // Package pin counts served
    localparam int PINS_SMALL = 64;
    localparam int PINS_LARGE = 80;

    // comparator_control_reg layout, bit 7 first
    typedef struct packed {
        logic enable_bit;
        logic output_to_pin;
        logic output_invert;
        logic [1:0] event_polarity;
        logic reference_select;
        logic [1:0] inverting_input_select;
    } dcc_ctrl_t;

    // Selections handed to one analog comparator core
    typedef struct packed {
        logic power_on;
        logic noninv_from_ref;
        logic [1:0] inv_sel;
        logic inv_connected;
    } dcc_ana_t;

endpackage : dcc_pkg

/* hdl/dcc_sync.sv */
/*
 * Two-flop synchroniser for the asynchronous comparator results.
 * Assumes the inputs change no faster than a few clock periods.
 */
`timescale 1ns/10ps
module dcc_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [1:0][WIDTH-1:0] st;
    logic [1:0][WIDTH-1:0] next_st;

    always_comb
    begin
        next_st[0] = async_i;
        next_st[1] = st[0];
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_o = st[1];

endmodule : dcc_sync

/* hdl/dcc_top.sv */
/*
 * Dual comparator control: per-comparator control registers, input
 * selection to the analog cores, polarity, pin output mux, status and
 * event flags with interrupt gating, reached over APB.
 * Assumes the analog cores report raw results asynchronously and that
 * the pad logic resolves the pins from pin_out_o and pin_oe_n_o.
 */
// Functional notes
// (R1) Comparator powered and running only while its enable_bit is set.
// (R2) inverting_input_select routes pin B, C, D or fixed reference to inverting input.
// (R3) Encoding 00 pin B, 01 pin C, 10 pin D, 11 fixed reference.
// (R4) reference_select clear connects non-inverting input to input pin A.
// (R5) reference_select set connects programmable reference to non-inverting input.
// (R6) Result high when non-inverting input exceeds inverting input, uninverted.
// (R7) output_invert inverts result for status, pin and event detector.
// (R8) Status bit 0 shows comparator 1, bit 1 comparator 2; read-only.
// (R9) output_to_pin switches the port pin from port data to result.
// (R10) Port direction bits stay the pin output enables meanwhile.
// (R11) event_polarity picks which result transitions set the flag.
// (R12) Mode 01 sets on rising result, mode 10 on falling result.
// (R13) Mode 11 sets the flag on every result change.
// (R14) Mode 00 never sets the flag from transitions.
// (R15) Writing mode 11 into event_polarity sets the flag itself.
// (R16) Flags live in bits 6:5 of the flag register.
// (R17) A set flag stays set until software writes zero.
// (R18) Software writing one to a flag sets it.
// (R19) Request raised only with flag, own, peripheral and global enables set.
// (R20) Flags set on events even when interrupt enables are clear.
// (R21) Inversion acts like swapping inputs; edges follow the inverted result.
// (R22) Software must make the selected input pin an analog input.
// (R23) Small package lacks C and D; large lacks D on comparator 1.
// (R24) Reset returns both control registers to reset values, comparators off.
// (R25) Raw results synchronised before edge detection and status capture.
// (R26) A disabled comparator presents a constant result and raises no events; here it is held low, so disabling while high sets the flag in modes 10 and 11.
`timescale 1ns/10ps
module dcc_top #(
    parameter int PKG_PINS = dcc_pkg::PINS_LARGE
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // APB slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Analog comparator cores, index 0 is comparator 1
    input wire logic [1:0] cmp_raw_i,
    output dcc_pkg::dcc_ana_t [1:0] ana_o,
    // Comparator output pins, index 0 is comparator 1
    output logic [1:0] pin_out_o,
    output logic [1:0] pin_oe_n_o,
    // Interrupt requests, index 0 is comparator 1
    output logic [1:0] irq_o
);

    typedef struct packed {
        dcc_pkg::dcc_ctrl_t [1:0] ctrl;
        dcc_pkg::dcc_ana_t [1:0] ana;
        logic [1:0] res;
        logic [1:0] flag;
        logic [1:0] ien;
        logic peripheral_irq_enable;
        logic global_irq_enable;
        logic [1:0] pdir;
        logic [1:0] pdat;
        logic [1:0] pin_out;
        logic [1:0] irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dcc_state_t;

    localparam dcc_state_t STATE_RST = '{
        ctrl: {dcc_pkg::CTRL_RST, dcc_pkg::CTRL_RST},
        ana: '0,
        res: '0,
        flag: '0,
        ien: '0,
        peripheral_irq_enable: 1'b0,
        global_irq_enable: 1'b0,
        pdir: dcc_pkg::PDIR_RST,
        pdat: dcc_pkg::PDAT_RST,
        pin_out: '0,
        irq: '0,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0
    };

    // Only the two bonded package sizes are served
    if (PKG_PINS != dcc_pkg::PINS_SMALL && PKG_PINS != dcc_pkg::PINS_LARGE)
    begin : g_pins_chk
        $error("dcc_top: PKG_PINS must be 64 or 80");
    end

    // Whether an inverting-input choice is bonded out on this package
    function automatic logic inm_avail(input int idx, input logic [1:0] sel);
        logic ok;
        ok = 1'b1;
        if (sel == dcc_pkg::INM_PIN_C || sel == dcc_pkg::INM_PIN_D)
        begin
            if (PKG_PINS == dcc_pkg::PINS_SMALL)
            begin
                ok = 1'b0; // [R23]
            end
            else if (idx == 0 && sel == dcc_pkg::INM_PIN_D)
            begin
                ok = 1'b0; // [R23]
            end
        end
        return ok;
    endfunction : inm_avail

    // Transition qualification for one comparator
    function automatic logic evt_hit(input logic [1:0] mode, input logic prev, input logic cur);
        logic hit;
        case (mode)
            dcc_pkg::EVT_RISE: hit = !prev && cur; // [R12]
            dcc_pkg::EVT_FALL: hit = prev && !cur; // [R12]
            dcc_pkg::EVT_ANY: hit = prev ^ cur; // [R13]
            default: hit = 1'b0; // [R14]
        endcase
        return hit;
    endfunction : evt_hit

    dcc_state_t st;
    dcc_state_t next_st;
    logic [1:0] raw_sync;

    // Raw results cross into the clock domain before any use
    dcc_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .async_i(cmp_raw_i), // [R25] [R6]
        .sync_o(raw_sync)
    );

    logic setup;
    logic wr_en;
    logic mapped;
    logic [1:0] cur_res;
    logic [1:0] hw_evt;
    logic [1:0] mode_set;
    logic [1:0] flag_wr;
    logic [31:0] rd_val;

    always_comb
    begin
        next_st = st;
        setup = psel_i && !penable_i;
        wr_en = psel_i && penable_i && st.pready && pwrite_i && !st.pslverr;
        cur_res = '0;
        hw_evt = '0;
        mode_set = '0;
        flag_wr = st.flag;
        rd_val = '0;

        // Polarity-adjusted result; constant low while disabled
        for (int i = 0; i < 2; i++)
        begin
            cur_res[i] = st.ctrl[i].enable_bit && (raw_sync[i] ^ st.ctrl[i].output_invert); // [R7] [R21] [R26]
            hw_evt[i] = evt_hit(st.ctrl[i].event_polarity, st.res[i], cur_res[i]); // [R11] [R20]
        end
        next_st.res = cur_res;

        // Register decode
        case (paddr_i)
            dcc_pkg::OFF_CTRL1: rd_val[7:0] = st.ctrl[0];
            dcc_pkg::OFF_CTRL2: rd_val[7:0] = st.ctrl[1];
            dcc_pkg::OFF_STAT: rd_val[1:0] = st.res; // [R8]
            dcc_pkg::OFF_FLAG:
            begin
                rd_val[dcc_pkg::FLAG_CM1_BIT] = st.flag[0]; // [R16]
                rd_val[dcc_pkg::FLAG_CM2_BIT] = st.flag[1]; // [R16]
            end
            dcc_pkg::OFF_IEN:
            begin
                rd_val[dcc_pkg::FLAG_CM1_BIT] = st.ien[0];
                rd_val[dcc_pkg::FLAG_CM2_BIT] = st.ien[1];
            end
            dcc_pkg::OFF_MCTL:
            begin
                rd_val[dcc_pkg::MCTL_PERIPHERAL_IRQ_ENABLE_BIT] = st.peripheral_irq_enable;
                rd_val[dcc_pkg::MCTL_GIE_BIT] = st.global_irq_enable;
            end
            dcc_pkg::OFF_PDIR:
            begin
                rd_val[dcc_pkg::PDIR_CM1_BIT] = st.pdir[0];
                rd_val[dcc_pkg::PDIR_CM2_BIT] = st.pdir[1];
            end
            dcc_pkg::OFF_PDAT:
            begin
                rd_val[dcc_pkg::PDIR_CM1_BIT] = st.pdat[0];
                rd_val[dcc_pkg::PDIR_CM2_BIT] = st.pdat[1];
            end
            default: rd_val = '0;
        endcase
        mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= dcc_pkg::OFF_PDAT);

        // Answer comes in the access phase, one edge after setup
        next_st.pready = setup;
        next_st.pslverr = setup && !mapped;
        if (setup)
        begin
            next_st.prdata = (mapped && !pwrite_i) ? rd_val : '0;
        end

        if (wr_en)
        begin
            case (paddr_i)
                dcc_pkg::OFF_CTRL1:
                begin
                    next_st.ctrl[0] = pwdata_i[7:0];
                    mode_set[0] = pwdata_i[4:3] == dcc_pkg::EVT_ANY; // [R15]
                end
                dcc_pkg::OFF_CTRL2:
                begin
                    next_st.ctrl[1] = pwdata_i[7:0];
                    mode_set[1] = pwdata_i[4:3] == dcc_pkg::EVT_ANY; // [R15]
                end
                dcc_pkg::OFF_FLAG:
                begin
                    flag_wr[0] = pwdata_i[dcc_pkg::FLAG_CM1_BIT]; // [R17] [R18]
                    flag_wr[1] = pwdata_i[dcc_pkg::FLAG_CM2_BIT]; // [R17] [R18]
                end
                dcc_pkg::OFF_IEN:
                begin
                    next_st.ien[0] = pwdata_i[dcc_pkg::FLAG_CM1_BIT];
                    next_st.ien[1] = pwdata_i[dcc_pkg::FLAG_CM2_BIT];
                end
                dcc_pkg::OFF_MCTL:
                begin
                    next_st.peripheral_irq_enable = pwdata_i[dcc_pkg::MCTL_PERIPHERAL_IRQ_ENABLE_BIT];
                    next_st.global_irq_enable = pwdata_i[dcc_pkg::MCTL_GIE_BIT];
                end
                dcc_pkg::OFF_PDIR:
                begin
                    next_st.pdir[0] = pwdata_i[dcc_pkg::PDIR_CM1_BIT];
                    next_st.pdir[1] = pwdata_i[dcc_pkg::PDIR_CM2_BIT];
                end
                dcc_pkg::OFF_PDAT:
                begin
                    next_st.pdat[0] = pwdata_i[dcc_pkg::PDIR_CM1_BIT];
                    next_st.pdat[1] = pwdata_i[dcc_pkg::PDIR_CM2_BIT];
                end
                default:
                begin
                    next_st.ien = st.ien;
                end
            endcase
        end

        // Hardware sets win over a software clear in the same cycle
        next_st.flag = flag_wr | hw_evt | mode_set; // [R17] [R20]

        for (int i = 0; i < 2; i++)
        begin
            next_st.ana[i].power_on = next_st.ctrl[i].enable_bit; // [R1]
            next_st.ana[i].noninv_from_ref = next_st.ctrl[i].reference_select; // [R4] [R5]
            next_st.ana[i].inv_sel = next_st.ctrl[i].inverting_input_select; // [R2] [R3]
            next_st.ana[i].inv_connected = next_st.ctrl[i].enable_bit
                && inm_avail(i, next_st.ctrl[i].inverting_input_select); // [R23]
            next_st.pin_out[i] = next_st.ctrl[i].output_to_pin ? cur_res[i] : next_st.pdat[i]; // [R9] [R7]
            next_st.irq[i] = next_st.flag[i] && next_st.ien[i] && next_st.peripheral_irq_enable && next_st.global_irq_enable; // [R19]
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= STATE_RST; // [R24]
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign ana_o = st.ana;
    assign pin_out_o = st.pin_out;
    assign pin_oe_n_o = st.pdir; // [R10]
    assign irq_o = st.irq;

endmodule : dcc_top

/* test/dcc_ana_model.sv */
/* Analog core model for one comparator.
   Assumes lvl_i holds pins A, B, C, D, fixed and programmable reference. */
`timescale 1ns/10ps
module dcc_ana_model (
    // Clock and selection
    input wire logic core_clk_i,
    input wire dcc_pkg::dcc_ana_t ana_i,
    // Input levels
    input wire logic [5:0][7:0] lvl_i,
    // Raw result
    output logic raw_o
);
    logic [7:0] vp;
    logic [7:0] vn;
    logic junk = 1'b0;
    // An unpowered core output wanders every cycle
    always_ff @(posedge core_clk_i)
        junk <= !junk;
    assign vp = ana_i.noninv_from_ref ? lvl_i[5] : lvl_i[0];
    assign vn = lvl_i[3'(ana_i.inv_sel) + 3'd1];
    assign raw_o = (ana_i.power_on && ana_i.inv_connected) ? (vp > vn) : junk;
endmodule : dcc_ana_model

/* test/dcc_properties.sv */
/* Port checker for dcc_top.
   Assumes register writes land at the APB access edge. */
`timescale 1ns/10ps
module dcc_props (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // APB
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Comparator side
    input wire dcc_pkg::dcc_ana_t [1:0] ana_o,
    input wire logic [1:0] irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic [7:0] mst;
    // Shadow of the master enables
    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            mst <= 8'h00;
        else if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == dcc_pkg::OFF_MCTL)
            mst <= pwdata_i[7:0];
    end
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    property p_ready; s_setup |=> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("no pready after setup");
    property p_once; pready_o |=> !pready_o; endproperty
    a_once: assert property (p_once) else $error("pready longer than one cycle");
    property p_unmapped; pready_o && paddr_i > 8'h1c |-> pslverr_o; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_err_ready; pslverr_o |-> pready_o; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_stat; pready_o && !pwrite_i && paddr_i == dcc_pkg::OFF_STAT |-> prdata_o[31:2] == 30'h0; endproperty
    a_stat: assert property (p_stat) else $error("status upper bits not zero");
    property p_hold; irq_o[0] && !psel_i |=> irq_o[0]; endproperty
    a_hold: assert property (p_hold) else $error("request dropped without a write");
    property p_gate; irq_o != 2'b00 |-> mst[7] && mst[6]; endproperty
    a_gate: assert property (p_gate) else $error("request without master enables");
    property p_off;
        !ana_o[0].power_on || ana_o[0].inv_sel == dcc_pkg::INM_PIN_D |-> !ana_o[0].inv_connected;
    endproperty
    a_off: assert property (p_off) else $error("input connected while off or absent");
endmodule : dcc_props
bind dcc_top dcc_props i_props (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ana_o(ana_o), .irq_o(irq_o));

/* test/dual_comparator_control_tb.sv */
/* Random bench for dcc_top with two analog core models.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
module dual_comparator_control_tb;
    logic core_clk_i;
    logic nrst_i;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] raw;
    dcc_pkg::dcc_ana_t [1:0] ana;
    logic [1:0] pin;
    logic [1:0] oe_n;
    logic [1:0] irq;
    logic [5:0][7:0] lvl;
    logic [1:0][7:0] cfg;
    logic [7:0] ien;
    logic [7:0] mc;
    logic [7:0] pd;
    logic [7:0] pt;
    logic [31:0] q;
    logic sl;
    logic h;
    logic [1:0] r0;
    logic [1:0] r1;
    logic [1:0] f;
    int err_total;
    int num_checks;
    dcc_top #(.PKG_PINS(dcc_pkg::PINS_LARGE)) i_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .cmp_raw_i(raw), .ana_o(ana), .pin_out_o(pin),
        .pin_oe_n_o(oe_n), .irq_o(irq));
    dcc_ana_model i_cm1 (.core_clk_i(core_clk_i), .ana_i(ana[0]), .lvl_i(lvl), .raw_o(raw[0]));
    dcc_ana_model i_cm2 (.core_clk_i(core_clk_i), .ana_i(ana[1]), .lvl_i(lvl), .raw_o(raw[1]));
    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = !core_clk_i;
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk_i);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge core_clk_i);
        penable <= 1'b1;
        @(posedge core_clk_i);
        while (pready !== 1'b1)
            @(posedge core_clk_i);
        q = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // Positive inputs sit clear of the negative band in either state
    task automatic set_lvl(input logic hi);
        for (int i = 0; i < 6; i++)
            lvl[i] <= (i == 0 || i == 5) ? (hi ? 8'hc0 : 8'h00) + 8'($urandom % 64) : 8'h50 + 8'($urandom % 96);
    endtask : set_lvl
    function automatic logic [1:0] res(input logic hi);
        return {cfg[1][7] & (hi ^ cfg[1][5]), cfg[0][7] & (hi ^ cfg[0][5])};
    endfunction : res
    function automatic logic evt(input logic [1:0] m, input logic a, input logic b);
        return (m == dcc_pkg::EVT_RISE && b && !a) || (m == dcc_pkg::EVT_FALL && a && !b)
            || (m == dcc_pkg::EVT_ANY && a != b);
    endfunction : evt
    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        err_total++;
        end_sim();
    end
    initial
    begin
        nrst_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lvl = '0;
        err_total = 0;
        num_checks = 0;
        void'($urandom(25));
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        apb(dcc_pkg::OFF_CTRL1, 1'b0, 32'h0);
        chk(q, 32'h1f);
        apb(dcc_pkg::OFF_CTRL2, 1'b0, 32'h0);
        chk(q, 32'h1f);
        apb(dcc_pkg::OFF_STAT, 1'b1, 32'hff);
        apb(dcc_pkg::OFF_STAT, 1'b0, 32'h0);
        chk(q, 32'h0);
        apb(8'h20, 1'b0, 32'h0);
        chk({31'h0, sl}, 32'h1);
        apb(dcc_pkg::OFF_CTRL2, 1'b1, 32'h18);
        apb(dcc_pkg::OFF_FLAG, 1'b0, 32'h0);
        chk(q, 32'h40);
        apb(dcc_pkg::OFF_FLAG, 1'b1, 32'h20);
        repeat (8) @(posedge core_clk_i);
        apb(dcc_pkg::OFF_FLAG, 1'b0, 32'h0);
        chk(q, 32'h20);
        apb(dcc_pkg::OFF_CTRL1, 1'b1, 32'h82);
        @(posedge core_clk_i);
        chk({27'h0, ana[0]}, {27'h0, 1'b1, 1'b0, dcc_pkg::INM_PIN_D, 1'b0});
        apb(dcc_pkg::OFF_CTRL1, 1'b1, 32'h0);
        $display("register test done");
        for (int it = 0; it < 40; it++)
        begin
            cfg[0] = 8'($urandom);
            cfg[1] = 8'($urandom);
            if (cfg[0][1:0] == dcc_pkg::INM_PIN_D)
                cfg[0][1:0] = dcc_pkg::INM_PIN_C;
            ien = 8'($urandom);
            mc = 8'($urandom);
            pd = 8'($urandom);
            pt = 8'($urandom);
            h = 1'($urandom);
            set_lvl(h);
            apb(dcc_pkg::OFF_CTRL1, 1'b1, {24'h0, cfg[0]});
            apb(dcc_pkg::OFF_CTRL2, 1'b1, {24'h0, cfg[1]});
            apb(dcc_pkg::OFF_IEN, 1'b1, {24'h0, ien});
            apb(dcc_pkg::OFF_MCTL, 1'b1, {24'h0, mc});
            apb(dcc_pkg::OFF_PDIR, 1'b1, {24'h0, pd});
            apb(dcc_pkg::OFF_PDAT, 1'b1, {24'h0, pt});
            repeat (6) @(posedge core_clk_i);
            apb(dcc_pkg::OFF_FLAG, 1'b1, 32'h0);
            r0 = res(h);
            set_lvl(!h);
            repeat (6) @(posedge core_clk_i);
            r1 = res(!h);
            f = {evt(cfg[1][4:3], r0[1], r1[1]), evt(cfg[0][4:3], r0[0], r1[0])};
            apb(dcc_pkg::OFF_STAT, 1'b0, 32'h0);
            chk(q, {30'h0, r1});
            apb(dcc_pkg::OFF_FLAG, 1'b0, 32'h0);
            chk(q, {25'h0, f, 5'h0});
            chk({30'h0, irq}, {30'h0, f & ien[6:5] & {2{mc[7] & mc[6]}}});
            chk({30'h0, pin}, {30'h0, cfg[1][6] ? r1[1] : pt[1], cfg[0][6] ? r1[0] : pt[2]});
            chk({30'h0, oe_n}, {30'h0, pd[1], pd[2]});
            for (int c = 0; c < 2; c++)
                chk({27'h0, ana[c]}, {27'h0, cfg[c][7], cfg[c][2], cfg[c][1:0], cfg[c][7]});
        end
        $display("random test done");
        end_sim();
    end
endmodule : dual_comparator_control_tb
